// >>> testbench/channel_clock_divider_checker.sv
// Purpose: Port-level assertions for the channel clock divider.
// Assumes: Clock enable stays high while outputs are judged.
// Notes:   Divider 1 control is shadowed from bus writes at their taking edge.
`timescale 1ns/1ps
module channel_clock_divider_checker
  import chdiv_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        SYNC_N,
  input wire logic        CHANNEL_OUT_A,
  input wire logic        CHANNEL_OUT_B,
  input wire logic        DIV1_OUT_A,
  input wire logic        DIV1_OUT_B,
  input wire logic        DIV0_DUTY_CORR_EN
);
  logic [7:0] ctl1_reg;  // Divider 1 control as last written.
  logic [3:0] age_reg;   // Cycles since that control changed.
  logic [3:0] low_reg;   // Cycles the sync pin has been low.
  logic       take;      // A bus request is taken at this edge.
  assign take = CYC_I & STB_I & ~ACK_O & CE;

  // Age gating hides the counter and output register latency after a control write.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctl1_reg <= RST_DIV1_CONTROL;
      age_reg  <= 4'h0;
    end else if (take && WE_I && SEL_I[0] && ADR_I[11:2] == IDX_DIV1_CONTROL) begin
      ctl1_reg <= DAT_I[7:0];
      age_reg  <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end

  // Saturating count of a held sync request.
  always_ff @(posedge CLK_SYS) begin
    if (RST || SYNC_N) low_reg <= 4'h0;
    else if (low_reg != 4'hf) low_reg <= low_reg + 4'h1;
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  ack_answer_a: assert property (take |=> ACK_O)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (ACK_O && CE |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
    else $error("acknowledge without request");
  read_upper_a: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
    else $error("upper read bits not zero");
  pair_equal_a: assert property (CHANNEL_OUT_A == CHANNEL_OUT_B && DIV1_OUT_A == DIV1_OUT_B)
    else $error("output pair pins differ");
  duty_write_a: assert property (take && WE_I && SEL_I[0] && ADR_I[11:2] == IDX_DIV0_ROUTING
    |-> ##2 DIV0_DUTY_CORR_EN == !$past(DAT_I[0], 2))
    else $error("duty correction enable wrong");
  reset_state_a: assert property ($fell(RST) |-> !ACK_O && DIV0_DUTY_CORR_EN && !DIV1_OUT_A)
    else $error("outputs wrong after reset");
  force_static_a: assert property (age_reg > 4'h7 && ctl1_reg[7:6] == 2'b01
    |-> DIV1_OUT_A == ctl1_reg[5])
    else $error("forced level wrong");
  sync_hold_a: assert property (low_reg > 4'h7 && age_reg > 4'h7 && ctl1_reg[7:6] == 2'b00
    |-> DIV1_OUT_A == ctl1_reg[4])
    else $error("start level not held in sync");
endmodule : channel_clock_divider_checker

bind channel_clock_divider channel_clock_divider_checker chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .SYNC_N(SYNC_N), .CHANNEL_OUT_A(CHANNEL_OUT_A),
  .CHANNEL_OUT_B(CHANNEL_OUT_B), .DIV1_OUT_A(DIV1_OUT_A), .DIV1_OUT_B(DIV1_OUT_B),
  .DIV0_DUTY_CORR_EN(DIV0_DUTY_CORR_EN));

// >>> testbench/channel_clock_divider_tb_top.sv
// Purpose: Self-checking bench for the channel clock divider.
// Assumes: CLK pin has half period 3 cycles, VCO pin 4 cycles.
// Notes:   Output run lengths are judged through two load models.
`timescale 1ns/1ps
module channel_clock_divider_tb_top;
  import chdiv_pkg::*;
  logic        clk_sys, ce, rst, cyc, stb, we, vco_in, clk_in, sync_n;
  logic [11:0] adr;
  logic [31:0] dat_w, dat_r;
  logic [3:0]  sel;
  logic        ack, out_a, out_b, d1_a, d1_b, duty_en;
  logic [7:0]  hi0, lo0, hi1, lo1;  // Run lengths seen by the loads.
  int          n_mismatch, num_checks, cycles, phase;

  channel_clock_divider uut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(dat_w), .SEL_I(sel), .DAT_O(dat_r),
    .ACK_O(ack), .VCO_IN(vco_in), .CLK_IN(clk_in), .SYNC_N(sync_n),
    .CHANNEL_OUT_A(out_a), .CHANNEL_OUT_B(out_b), .DIV1_OUT_A(d1_a),
    .DIV1_OUT_B(d1_b), .DIV0_DUTY_CORR_EN(duty_en));
  clock_load_model load0 (.clk(clk_sys), .rst(rst), .lvl(out_a), .hi_len(hi0), .lo_len(lo0));
  clock_load_model load1 (.clk(clk_sys), .rst(rst), .lvl(d1_a), .hi_len(hi1), .lo_len(lo1));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Source pins move on the rising edge, slow enough to be counted.
  always @(posedge clk_sys) begin
    phase <= (phase == 11) ? 0 : phase + 1;
    if (phase % 3 == 0) clk_in <= ~clk_in;
    if (phase % 4 == 0) vco_in <= ~vco_in;
  end

  // Cut a hang short well beyond the few thousand cycles the tests need.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high at a rise.
  // Only the bench timeout ends a wait for an answer that never comes.
  task automatic wb(input logic [9:0] idx, input logic w, input logic [7:0] wd,
                    input logic s0, output logic [7:0] rd);
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'b00};
    dat_w <= {24'h0, wd};
    sel   <= {3'h0, s0};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(idx, 1'b1, d, 1'b1, x);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
    logic [7:0] x;
    wb(idx, 1'b0, 8'h00, 1'b0, x);
    check({24'h0, x}, {24'h0, e});
  endtask : rd_chk

  // Settle past any partial run, then judge full high and low runs.
  task automatic meas(input logic d1, input logic [7:0] eh, input logic [7:0] el);
    repeat (250) @(posedge clk_sys);
    @(negedge clk_sys);
    check({24'h0, d1 ? hi1 : hi0}, {24'h0, eh});
    check({24'h0, d1 ? lo1 : lo0}, {24'h0, el});
  endtask : meas

  task automatic lvl(input logic e);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, d1_a}, {31'h0, e});
  endtask : lvl

  task automatic test_regs();
    logic [7:0] x;
    rd_chk(IDX_DIV0_COUNTS, 8'h00);
    rd_chk(IDX_DIV0_CONTROL, 8'h80);
    rd_chk(IDX_DIV0_ROUTING, 8'h00);
    rd_chk(IDX_DIV1_COUNTS, 8'hbb);
    rd_chk(IDX_DIV1_CONTROL, 8'h00);
    rd_chk(IDX_SOURCE_SEL, 8'h00);
    wr(10'h000, 8'hff);
    rd_chk(10'h000, 8'h00);
    wb(IDX_DIV1_CONTROL, 1'b1, 8'h0f, 1'b0, x);
    rd_chk(IDX_DIV1_CONTROL, 8'h00);
    wr(IDX_DIV0_CONTROL, 8'h5f);
    rd_chk(IDX_DIV0_CONTROL, 8'h5f);
  endtask : test_regs

  // Each count step is one CLK pin period of six cycles.
  task automatic test_divide();
    meas(1'b1, 8'd72, 8'd72);
    wr(IDX_DIV1_COUNTS, 8'h21);
    meas(1'b1, 8'd12, 8'd18);
    wr(IDX_DIV1_COUNTS, 8'h00);
    meas(1'b1, 8'd6, 8'd6);
  endtask : test_divide

  task automatic test_modes();
    wr(IDX_DIV1_CONTROL, 8'h80);
    meas(1'b1, 8'd3, 8'd3);
    wr(IDX_DIV1_CONTROL, 8'he0);
    meas(1'b1, 8'd3, 8'd3);
    wr(IDX_DIV1_CONTROL, 8'h60);
    lvl(1'b1);
    wr(IDX_DIV1_CONTROL, 8'h40);
    lvl(1'b0);
    wr(IDX_DIV1_CONTROL, 8'h10);
    sync_n <= 1'b0;
    lvl(1'b1);
    wr(IDX_DIV1_CONTROL, 8'h00);
    lvl(1'b0);
    wr(IDX_DIV1_CONTROL, 8'h50);
    lvl(1'b0);
    sync_n <= 1'b1;
    wr(IDX_DIV1_CONTROL, 8'h00);
  endtask : test_modes

  // Release sync at a fixed pin phase and count cycles to the first rise.
  task automatic sync_run(input logic [7:0] ctl, output int t);
    wr(IDX_DIV1_CONTROL, ctl);
    sync_n <= 1'b0;
    lvl(1'b0);
    do @(posedge clk_sys); while (phase != 0);
    sync_n <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (d1_a !== 1'b1);
  endtask : sync_run

  // Three phase steps hold the first edge back by three CLK periods;
  // then a low clock enable must freeze the running divider.
  task automatic test_phase();
    int   t0, t3;
    logic v;
    sync_run(8'h00, t0);
    sync_run(8'h03, t3);
    check(t3 - t0, 32'd18);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (2) @(negedge clk_sys);
    v = d1_a;
    repeat (30) @(negedge clk_sys);
    check({31'h0, d1_a}, {31'h0, v});
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask : test_phase

  task automatic test_routing();
    wr(IDX_DIV0_CONTROL, 8'h00);
    wr(IDX_DIV0_COUNTS, 8'h00);
    meas(1'b0, 8'd6, 8'd6);
    wr(IDX_DIV0_ROUTING, 8'h03);
    repeat (3) @(negedge clk_sys);
    check({31'h0, duty_en}, 32'h0);
    meas(1'b0, 8'd3, 8'd3);
    wr(IDX_SOURCE_SEL, 8'h02);
    meas(1'b0, 8'd4, 8'd4);
    wr(IDX_SOURCE_SEL, 8'h01);
    meas(1'b0, 8'd6, 8'd6);
  endtask : test_routing

  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial begin
    {ce, rst, cyc, stb, we, vco_in, clk_in, sync_n} = 8'hc1;
    {adr, dat_w, sel} = 48'h0;
    {n_mismatch, num_checks, cycles, phase} = 128'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_divide();
    test_modes();
    test_phase();
    test_routing();
    print_verdict();
  end
endmodule : channel_clock_divider_tb_top

// >>> testbench/clock_load_model.sv
// Purpose: Clock load on one output pin; measures high and low run lengths.
// Assumes: Runs are counted in system clock cycles.
// Notes:   A load only listens, so it binds nothing on the device.
`timescale 1ns/1ps
module clock_load_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       lvl,
  output logic      [7:0] hi_len,
  output logic      [7:0] lo_len
);
  logic       last_reg;  // Level seen at the previous edge.
  logic [7:0] run_reg;   // Length of the run in progress.

  // A finished run is filed by its level; the counter saturates on a stuck pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      last_reg <= 1'b0;
      run_reg  <= 8'h00;
      hi_len   <= 8'h00;
      lo_len   <= 8'h00;
    end else if (lvl != last_reg) begin
      if (last_reg) hi_len <= run_reg;
      else lo_len <= run_reg;
      run_reg  <= 8'h01;
      last_reg <= lvl;
    end else if (run_reg != 8'hff) begin
      run_reg <= run_reg + 8'h01;
    end
  end
endmodule : clock_load_model

// >>> verilog/channel_clock_divider.sv
// Purpose: Two channel clock dividers with Wishbone registers and output routing.
// Assumes: VCO_IN, CLK_IN and SYNC_N are asynchronous pins, sampled on CLK_SYS.
// Notes:   Source pins must be slower than half of CLK_SYS to be counted.
//
// Function
// - Output low for low count plus one.
// - Output high for high count plus one.
// - Bypass passes source straight to output.
// - Ignore-sync bit masks the chip sync; here it also halts the divider and holds the output at the force bit level.
// - Force bit sets static level, needs ignore-sync.
// - Force has no effect during bypass.
// - Start-level bit picks initial output level.
// - Four-bit phase offset, resets to zero.
// - Direct route picks VCO or CLK input.
// - Duty correction on when bit clear.
// - Divider 1 counts reset 0xB, divider 0 zero.
// - Divider 0 resets bypassed, divider 1 not.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module channel_clock_divider #(
  parameter int CNT_W = 4
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [11:0] ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        VCO_IN,
  input  wire logic        CLK_IN,
  input  wire logic        SYNC_N,
  output logic             CHANNEL_OUT_A,
  output logic             CHANNEL_OUT_B,
  output logic             DIV1_OUT_A,
  output logic             DIV1_OUT_B,
  output logic             DIV0_DUTY_CORR_EN
);
  import chdiv_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------------------
  logic [7:0]             div0_counts_reg;   // Divider 0 low and high counts.
  logic [7:0]             div0_control_reg;  // Divider 0 control.
  logic [7:0]             div0_routing_reg;  // Divider 0 routing and duty.
  logic [7:0]             div1_counts_reg;   // Divider 1 low and high counts.
  logic [7:0]             div1_control_reg;  // Divider 1 control.
  logic [7:0]             source_sel_reg;    // Channel source select.
  logic [31:0]            dat_o_reg;         // Registered read data.
  logic                   ack_reg;           // Registered acknowledge.
  logic [SYNC_STAGES-1:0] vco_sync_reg;      // VCO pin synchroniser.
  logic [SYNC_STAGES-1:0] clk_sync_reg;      // CLK pin synchroniser.
  logic [SYNC_STAGES-1:0] syn_sync_reg;      // Sync pin synchroniser.
  logic                   vco_prev_reg;      // Previous VCO level for edges.
  logic                   clk_prev_reg;      // Previous CLK level for edges.
  logic                   vco_level;         // Synchronised VCO level.
  logic                   clk_level;         // Synchronised CLK level.
  logic                   sync_active;       // Synchronised sync, active high.
  logic                   src_level;         // Selected divider source level.
  logic                   src_rise;          // Selected source rising edge.
  logic                   div0_out;          // Divider 0 output.
  logic                   div1_out;          // Divider 1 output.
  logic                   pair_a_reg;        // Divider 0 output pair level.
  logic                   pair_b_reg;        // Divider 1 output pair level.
  logic                   bus_req;           // New bus request this cycle.
  logic                   bus_wr;            // Write strobe on the low byte.
  logic [9:0]             bus_idx;           // Register index from the address.
  logic [7:0]             rd_byte;           // Read mux result.

  // ---------------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------------
  // The first stage feeds only the second stage; edges use the second stage
  // and one extra flop, so a metastable sample never reaches the counters.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      vco_sync_reg <= '0;
      clk_sync_reg <= '0;
      syn_sync_reg <= '1;
    end else if (CE) begin
      vco_sync_reg <= {vco_sync_reg[0], VCO_IN};
      clk_sync_reg <= {clk_sync_reg[0], CLK_IN};
      syn_sync_reg <= {syn_sync_reg[0], SYNC_N};
    end
  end

  // Previous levels for rising edge detection.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      vco_prev_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
    end else if (CE) begin
      vco_prev_reg <= vco_level;
      clk_prev_reg <= clk_level;
    end
  end

  assign vco_level   = vco_sync_reg[SYNC_STAGES-1];
  assign clk_level   = clk_sync_reg[SYNC_STAGES-1];
  assign sync_active = ~syn_sync_reg[SYNC_STAGES-1];

  // ---------------------------------------------------------------------------
  // Divider source selection.
  // ---------------------------------------------------------------------------
  // The oscillator feeds the dividers for codes with the upper bit set;
  // every other code uses the external clock input.
  always_comb begin
    if (source_sel_reg[1]) begin
      src_level = vco_level;
      src_rise  = vco_level & ~vco_prev_reg;
    end else begin
      src_level = clk_level;
      src_rise  = clk_level & ~clk_prev_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Dividers.
  // ---------------------------------------------------------------------------
  chdiv_counter #(
    .CNT_W (CNT_W)
  ) u_div0 (
    .clk         (CLK_SYS),
    .rst         (RST),
    .ce          (CE),
    .src_level   (src_level),
    .src_rise    (src_rise),
    .sync_active (sync_active),
    .low_cnt     (div0_counts_reg[LOW_MSB:LOW_LSB]),
    .high_cnt    (div0_counts_reg[HIGH_MSB:HIGH_LSB]),
    .bypass      (div0_control_reg[BIT_BYPASS]),
    .nosync      (div0_control_reg[BIT_NOSYNC]),
    .force_lvl   (div0_control_reg[BIT_FORCE]),
    .start_high  (div0_control_reg[BIT_START]),
    .phase       (div0_control_reg[PHASE_MSB:PHASE_LSB]),
    .div_out     (div0_out)
  );

  chdiv_counter #(
    .CNT_W (CNT_W)
  ) u_div1 (
    .clk         (CLK_SYS),
    .rst         (RST),
    .ce          (CE),
    .src_level   (src_level),
    .src_rise    (src_rise),
    .sync_active (sync_active),
    .low_cnt     (div1_counts_reg[LOW_MSB:LOW_LSB]),
    .high_cnt    (div1_counts_reg[HIGH_MSB:HIGH_LSB]),
    .bypass      (div1_control_reg[BIT_BYPASS]),
    .nosync      (div1_control_reg[BIT_NOSYNC]),
    .force_lvl   (div1_control_reg[BIT_FORCE]),
    .start_high  (div1_control_reg[BIT_START]),
    .phase       (div1_control_reg[PHASE_MSB:PHASE_LSB]),
    .div_out     (div1_out)
  );

  // ---------------------------------------------------------------------------
  // Output pair routing.
  // ---------------------------------------------------------------------------
  // Direct routing skips divider 0 entirely; codes 01b and 11b keep the divider.
  // The pair is re-registered, so it lags the divider by one cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pair_a_reg <= 1'b0;
      pair_b_reg <= 1'b0;
    end else if (CE) begin
      if (div0_routing_reg[BIT_DIRECT] && source_sel_reg[1:0] == SRC_VCO) begin
        pair_a_reg <= vco_level;
      end else if (div0_routing_reg[BIT_DIRECT] && source_sel_reg[1:0] == SRC_CLK) begin
        pair_a_reg <= clk_level;
      end else begin
        pair_a_reg <= div0_out;
      end
      pair_b_reg <= div1_out;
    end
  end

  assign CHANNEL_OUT_A     = pair_a_reg;
  assign CHANNEL_OUT_B     = pair_a_reg;
  assign DIV1_OUT_A        = pair_b_reg;
  assign DIV1_OUT_B        = pair_b_reg;
  // Correction itself sits in the analog output stage; this enables it.
  assign DIV0_DUTY_CORR_EN = ~div0_routing_reg[BIT_DCC_OFF];

  // ---------------------------------------------------------------------------
  // Wishbone decode.
  // ---------------------------------------------------------------------------
  // Every access is answered one cycle after the strobe, mapped or not, so
  // a master can never hang on a bad address.
  assign bus_req = CYC_I & STB_I & ~ack_reg;
  assign bus_wr  = bus_req & WE_I & SEL_I[0];
  assign bus_idx = ADR_I[11:2];

  // Read multiplexer over the implemented registers.
  always_comb begin
    case (bus_idx)
      IDX_DIV0_COUNTS:  rd_byte = div0_counts_reg;
      IDX_DIV0_CONTROL: rd_byte = div0_control_reg;
      IDX_DIV0_ROUTING: rd_byte = div0_routing_reg & ROUTING_MASK;
      IDX_DIV1_COUNTS:  rd_byte = div1_counts_reg;
      IDX_DIV1_CONTROL: rd_byte = div1_control_reg;
      IDX_SOURCE_SEL:   rd_byte = source_sel_reg & SOURCE_MASK;
      IDX_STATUS:       rd_byte = {3'h0, pair_b_reg, pair_a_reg, sync_active,
                                   div1_out, div0_out};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Acknowledge and read data.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_reg   <= 1'b0;
      dat_o_reg <= 32'h0000_0000;
    end else if (CE) begin
      ack_reg <= bus_req;
      if (bus_req && !WE_I) begin
        dat_o_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_o_reg;

  // ---------------------------------------------------------------------------
  // Register writes.
  // ---------------------------------------------------------------------------
  // Only byte lane 0 carries data; writes with it deselected are ignored.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      div0_counts_reg  <= RST_DIV0_COUNTS;
      div0_control_reg <= RST_DIV0_CONTROL;
      div0_routing_reg <= RST_DIV0_ROUTING;
      div1_counts_reg  <= RST_DIV1_COUNTS;
      div1_control_reg <= RST_DIV1_CONTROL;
      source_sel_reg   <= RST_SOURCE_SEL;
    end else if (CE && bus_wr) begin
      case (bus_idx)
        IDX_DIV0_COUNTS:  div0_counts_reg  <= DAT_I[7:0];
        IDX_DIV0_CONTROL: div0_control_reg <= DAT_I[7:0];
        IDX_DIV0_ROUTING: div0_routing_reg <= DAT_I[7:0] & ROUTING_MASK;
        IDX_DIV1_COUNTS:  div1_counts_reg  <= DAT_I[7:0];
        IDX_DIV1_CONTROL: div1_control_reg <= DAT_I[7:0];
        IDX_SOURCE_SEL:   source_sel_reg   <= DAT_I[7:0] & SOURCE_MASK;
        default: begin
          // Unmapped and read-only indices drop the write.
        end
      endcase
    end
  end

endmodule : channel_clock_divider

// >>> verilog/chdiv_counter.sv
// Purpose: One programmable divider: counts source rising edges to shape its output.
// Assumes: src_rise is a one-cycle pulse per source rising edge, on clk.
// Notes:   Output is registered; bypass follows the synchronised source level.
`timescale 1ns/1ps
module chdiv_counter #(
  parameter int CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             src_level,
  input  wire logic             src_rise,
  input  wire logic             sync_active,
  input  wire logic [CNT_W-1:0] low_cnt,
  input  wire logic [CNT_W-1:0] high_cnt,
  input  wire logic             bypass,
  input  wire logic             nosync,
  input  wire logic             force_lvl,
  input  wire logic             start_high,
  input  wire logic [CNT_W-1:0] phase,
  output logic                  div_out
);
  import chdiv_pkg::*;

  logic [CNT_W:0] remain_reg;  // Input edges left before the next transition.
  logic           out_reg;     // Divider output level.
  logic           sync_hold;   // Sync obeyed and asserted.

  assign sync_hold = sync_active & ~nosync;
  assign div_out   = out_reg;

  // ---------------------------------------------------------------------------
  // Counter and output.
  // ---------------------------------------------------------------------------
  // Bypass outranks force, and force outranks sync since it needs nosync.
  always_ff @(posedge clk) begin
    if (rst) begin
      remain_reg <= '0;
      out_reg    <= 1'b0;
    end else if (ce) begin
      if (bypass) begin
        // Counter is idle; the source level passes straight through.
        out_reg    <= src_level;
        remain_reg <= '0;
      end else if (nosync) begin
        // Force is honoured only while sync is ignored.
        out_reg <= force_lvl;
      end else if (sync_hold) begin
        // Hold the start level and preload phase plus the first level length.
        out_reg    <= start_high;
        remain_reg <= level_len(start_high, high_cnt, low_cnt) + {1'b0, phase};
      end else if (src_rise) begin
        if (remain_reg == '0) begin
          out_reg    <= ~out_reg;
          remain_reg <= level_len(~out_reg, high_cnt, low_cnt);
        end else begin
          remain_reg <= remain_reg - 1'b1;
        end
      end
    end
  end

endmodule : chdiv_counter

// >>> verilog/chdiv_pkg.sv
// Purpose: Shared constants, register map and helpers of the channel clock divider.
// Assumes: Registers are 8 bits wide and sit in the low byte of a 32-bit bus word.
// Notes:   Register indices are multiplied by four to form byte addresses.
package chdiv_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address = index * 4).
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_DIV0_COUNTS  = 10'h190;  // Divider 0 low and high counts.
  localparam logic [9:0] IDX_DIV0_CONTROL = 10'h191;  // Divider 0 control.
  localparam logic [9:0] IDX_DIV0_ROUTING = 10'h192;  // Divider 0 routing and duty.
  localparam logic [9:0] IDX_DIV1_COUNTS  = 10'h193;  // Divider 1 low and high counts.
  localparam logic [9:0] IDX_DIV1_CONTROL = 10'h194;  // Divider 1 control.
  localparam logic [9:0] IDX_SOURCE_SEL   = 10'h1e1;  // Channel source clock select.
  localparam logic [9:0] IDX_STATUS       = 10'h1f0;  // Read-only live status.

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int LOW_MSB       = 7;  // Low count field, upper nibble.
  localparam int LOW_LSB       = 4;
  localparam int HIGH_MSB      = 3;  // High count field, lower nibble.
  localparam int HIGH_LSB      = 0;
  localparam int BIT_BYPASS    = 7;  // Bypass and power down the counter.
  localparam int BIT_NOSYNC    = 6;  // Ignore the chip-level sync.
  localparam int BIT_FORCE     = 5;  // Forced static level.
  localparam int BIT_START     = 4;  // Start level.
  localparam int PHASE_MSB     = 3;  // Phase offset field.
  localparam int PHASE_LSB     = 0;
  localparam int BIT_DIRECT    = 1;  // Route raw source to the output pair.
  localparam int BIT_DCC_OFF   = 0;  // Duty-cycle correction disable.

  // ---------------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_DIV0_COUNTS  = 8'h00;
  localparam logic [7:0] RST_DIV0_CONTROL = 8'h80;
  localparam logic [7:0] RST_DIV0_ROUTING = 8'h00;
  localparam logic [7:0] RST_DIV1_COUNTS  = 8'hbb;
  localparam logic [7:0] RST_DIV1_CONTROL = 8'h00;
  localparam logic [7:0] RST_SOURCE_SEL   = 8'h00;
  localparam logic [7:0] ROUTING_MASK     = 8'h03;  // Implemented routing bits.
  localparam logic [7:0] SOURCE_MASK      = 8'h03;  // Implemented source bits.

  // ---------------------------------------------------------------------------
  // Source select codes.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SRC_CLK = 2'h0;  // External clock input.
  localparam logic [1:0] SRC_DIV = 2'h1;  // Direct route has no effect.
  localparam logic [1:0] SRC_VCO = 2'h2;  // Oscillator input.

  // Number of flip-flops in each pin synchroniser.
  localparam int SYNC_STAGES = 2;

  // Remaining-count value for holding a level: the field value itself,
  // since the count runs down to zero inclusive.
  function automatic logic [4:0] level_len(input logic       lvl,
                                           input logic [3:0] high_cnt,
                                           input logic [3:0] low_cnt);
    level_len = lvl ? {1'b0, high_cnt} : {1'b0, low_cnt};
  endfunction : level_len

endpackage : chdiv_pkg
